// ==== verilog/phic_pkg.sv ====
// Purpose: Shared constants and carriers for the printer host interface control block
// Assumes: One 10 MHz clock, processor strobes sampled as synchronous levels
// Notes: Select codes are the three-bit output index of each addressable latch
package phic_pkg;

  // Processor address bit positions
  localparam int ADDR_LEVEL_BIT = 13;
  localparam int ADDR_SEL_HI = 12;
  localparam int ADDR_SEL_LO = 10;
  localparam int ADDR_SRC_HI = 17;
  localparam int ADDR_SRC_LO = 15;
  localparam int ADDR_STROBE_HI = 13;

  // Status group select codes
  localparam logic [2:0] SG_PARITY_ERROR = 3'h0;
  localparam logic [2:0] SG_READY = 3'h1;
  localparam logic [2:0] SG_ONLINE = 3'h2;
  localparam logic [2:0] SG_BAND_ID_ONE = 3'h3;
  localparam logic [2:0] SG_TOP_OF_FORM = 3'h4;
  localparam logic [2:0] SG_BOTTOM_OF_FORM = 3'h5;
  localparam logic [2:0] SG_UNUSED = 3'h6;
  localparam logic [2:0] SG_DATA_REQUEST = 3'h7;

  // Auxiliary group select codes
  localparam logic [2:0] AG_TAPE_UPPER = 3'h0;
  localparam logic [2:0] AG_TAPE_ENABLE = 3'h1;
  localparam logic [2:0] AG_FORMAT_HIGH = 3'h2;
  localparam logic [2:0] AG_UNUSED = 3'h3;
  localparam logic [2:0] AG_ONLINE_LAMP = 3'h4;
  localparam logic [2:0] AG_TAPE_MOTOR = 3'h5;
  localparam logic [2:0] AG_USER_PATH = 3'h6;
  localparam logic [2:0] AG_BAND_ID_ZERO = 3'h7;

  // Strobe group code that loads the display
  localparam logic [3:0] STROBE_DISPLAY_LOAD = 4'hD;

  // Reset values of the latches
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DISPLAY_RESET = 8'h00;

  // Parity coverage choices
  localparam logic [1:0] PAR_EIGHT = 2'h0;
  localparam logic [1:0] PAR_SEVEN = 2'h1;
  localparam logic [1:0] PAR_SEVEN_PI = 2'h2;

  // Input bus source select codes
  localparam logic [2:0] SRC_FORMS_LENGTH = 3'h0;
  localparam logic [2:0] SRC_USER_CONTROL = 3'h1;
  localparam logic [2:0] SRC_SWITCH_GROUP2 = 3'h2;
  localparam logic [2:0] SRC_SWITCH_GROUP3 = 3'h3;
  localparam logic [2:0] SRC_SWITCH_GROUP4 = 3'h4;
  localparam logic [2:0] SRC_INTERLOCKS = 3'h5;
  localparam logic [2:0] SRC_PANEL = 3'h6;

  // Segment patterns, bit order g f e d c b a
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_LETTER_C = 7'h39;
  localparam logic [6:0] SEG_LETTER_P = 7'h73;
  localparam logic [6:0] SEG_LETTER_H = 7'h76;

  // Host-facing status lines
  typedef struct packed {
    logic data_request_line;
    logic bottom_of_form_line;
    logic top_of_form_line;
    logic band_id_bit_one;
    logic host_online_line;
    logic host_ready_line;
    logic host_parity_error_line;
  } phic_status_s;

  // Auxiliary control outputs
  typedef struct packed {
    logic band_id_bit_zero;
    logic user_path_enable;
    logic tape_motor_control;
    logic panel_online_lamp;
    logic format_high_select;
    logic tape_input_enable;
    logic tape_upper_half_select;
  } phic_aux_s;

  // Input bus sources
  typedef struct packed {
    logic [7:0] forms_length;
    logic [7:0] user_control;
    logic [7:0] switch_group2;
    logic [7:0] switch_group3;
    logic [7:0] switch_group4;
    logic [7:0] interlocks;
    logic [7:0] panel;
  } phic_sources_s;

endpackage : phic_pkg

// ==== verilog/phic_addr_latch.sv ====
// Purpose: Eight-output addressable latch with clear
// Assumes: Enable and select are synchronous to mclk_in
// Notes: Clear wins over a write in the same cycle
`timescale 1ns/1ns
module phic_addr_latch
  import phic_pkg::*;
(
  input wire logic mclk_in,
  input wire logic clear_in,
  input wire logic enable_in,
  input wire logic [2:0] select_in,
  input wire logic level_in,
  output logic [7:0] q_out
);

  // Only the addressed output moves; the others keep their last level
  always_ff @(posedge mclk_in) begin
    if (clear_in) begin
      q_out <= LATCH_RESET;
    end else if (enable_in) begin
      q_out[select_in] <= level_in;
    end
  end

endmodule : phic_addr_latch

// ==== verilog/phic_seg_decoder.sv ====
// Purpose: BCD digit to seven-segment pattern
// Assumes: Pattern bit order g f e d c b a, active high
// Notes: Codes above nine blank the digit
`timescale 1ns/1ns
module phic_seg_decoder
  import phic_pkg::*;
(
  input wire logic [3:0] digit_in,
  output logic [6:0] seg_out
);

  // Plain lookup; unused codes blank rather than show junk
  always_comb begin
    case (digit_in)
      4'h0: seg_out = 7'h3F;
      4'h1: seg_out = 7'h06;
      4'h2: seg_out = 7'h5B;
      4'h3: seg_out = 7'h4F;
      4'h4: seg_out = 7'h66;
      4'h5: seg_out = 7'h6D;
      4'h6: seg_out = 7'h7D;
      4'h7: seg_out = 7'h07;
      4'h8: seg_out = 7'h7F;
      4'h9: seg_out = 7'h6F;
      default: seg_out = SEG_BLANK;
    endcase
  end

endmodule : phic_seg_decoder

// ==== verilog/phic_host_iface.sv ====
// Purpose: Host-side interface control of a line printer: status and auxiliary control
//   latches, user data path with inversion and parity check, input source decode and
//   panel status display.
// Assumes: Processor strobes and address are synchronous to mclk_in; host pins are not.
// Notes: Host data and strobe pass a three-stage synchroniser before use.
//
// Summary of operation
// - Status latch writes only when enabled; address 12..10 selects, bit 13 is level.
// - Status codes 001 ready, 010 online, 111 data request follow bit 13.
// - Status codes 000 parity error, 100 top, 101 bottom of form; 110 unused.
// - Status code 011 sets band id bit one to bit 13.
// - Auxiliary latch writes only when enabled, same select and level bits.
// - Aux 000 picks tape channel half; aux 001 enables tape input.
// - Aux 010 picks low or high byte format memory pair.
// - Aux 100 drives panel online lamp; aux 011 unused.
// - Aux 101 switches tape reader motor.
// - Aux 110 enables user data and control path.
// - Aux 111 drives band id bit zero.
// - Every host data bit is exclusive-ORed; invert option inverts all bits.
// - User data latch captures on rising edge of the respond latch pulse.
// - Latched byte reaches register bus only with read strobe and path enable.
// - With parity option on, every incoming byte is parity checked.
// - Parity covers eight bits, seven bits, or seven bits plus paper instruction.
// - Expected parity comes from odd select and host parity bit; host drives it.
// - Processor loads parity error code onto panel digits via load display.
// - Source decoder enabled by condition bit with address bits 12 and 13.
// - Address bits 0F..11 select which source drives the input bus.
// - Panel digits decode BCD status bytes 00 to 99.
// - Clock, supply and heat faults force C, P, H on the display.
// - Latches hold unselected outputs; clear forces all outputs low.
// - Display load strobe is strobe group code 1101.
`timescale 1ns/1ns
module phic_host_iface
  import phic_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Processor side
  input wire logic [17:10] processor_address_bits_in,
  input wire logic status_group_enable_n_in,
  input wire logic aux_group_enable_n_in,
  input wire logic strobe_group_enable_n_in,
  input wire logic processor_condition_bit_n_in,
  input wire logic user_latch_read_strobe_n_in,
  input wire logic [7:0] processor_output_bus_in,
  output logic [7:0] processor_register_bus_out,
  output logic processor_register_bus_oe_out,
  output logic [7:0] processor_input_bus_out,
  output logic processor_input_bus_oe_out,
  output logic [6:0] source_enable_n_out,
  input wire phic_sources_s sources_in,
  // Host side
  input wire logic [7:0] host_data_in,
  input wire logic host_parity_bit_in,
  input wire logic paper_instruction_bit_in,
  input wire logic respond_latch_pulse_in,
  output phic_status_s status_out,
  output phic_aux_s aux_out,
  output logic parity_fault_out,
  // Options and faults
  input wire logic invert_input_option_in,
  input wire logic parity_option_in,
  input wire logic [1:0] parity_coverage_in,
  input wire logic odd_parity_select_in,
  input wire logic clock_fault_n_in,
  input wire logic supply_fault_n_in,
  input wire logic overtemp_fault_n_in,
  output logic display_load_strobe_n_out,
  output logic [6:0] display_tens_out,
  output logic [6:0] display_units_out
);

  // Parity of a byte under the chosen coverage
  function automatic logic cover_parity(input logic [7:0] d, input logic [1:0] cov,
                                        input logic pi);
    logic p;
    p = ^d[6:0];
    case (cov)
      PAR_EIGHT: p = p ^ d[7];
      PAR_SEVEN_PI: p = p ^ pi;
      default: p = p;
    endcase
    return p;
  endfunction : cover_parity

  logic clear;
  logic [2:0] select;
  logic level;
  logic [7:0] status_q;
  logic [7:0] aux_q;
  logic [2:0] src_sel;
  logic [10:0] host_sync1;
  logic [10:0] host_sync2;
  logic [10:0] host_sync3;
  logic strobe_seen;
  logic [7:0] user_byte;
  logic [7:0] next_user_byte;
  logic display_load;
  logic [7:0] display_code;
  logic [6:0] seg_tens;
  logic [6:0] seg_units;
  logic source_on;

  assign clear = ~reset_n_in;
  assign select = processor_address_bits_in[ADDR_SEL_HI:ADDR_SEL_LO];
  assign level = processor_address_bits_in[ADDR_LEVEL_BIT];

  // Status group latch; code 110 is stored but drives nothing
  phic_addr_latch u_status_latch (
    .mclk_in(mclk_in),
    .clear_in(clear),
    .enable_in(~status_group_enable_n_in),
    .select_in(select),
    .level_in(level),
    .q_out(status_q)
  );

  // Auxiliary group latch; code 011 is stored but drives nothing
  phic_addr_latch u_aux_latch (
    .mclk_in(mclk_in),
    .clear_in(clear),
    .enable_in(~aux_group_enable_n_in),
    .select_in(select),
    .level_in(level),
    .q_out(aux_q)
  );

  // Host status lines straight from the latch flops
  always_comb begin
    status_out.host_parity_error_line = status_q[SG_PARITY_ERROR];
    status_out.host_ready_line = status_q[SG_READY];
    status_out.host_online_line = status_q[SG_ONLINE];
    status_out.band_id_bit_one = status_q[SG_BAND_ID_ONE];
    status_out.top_of_form_line = status_q[SG_TOP_OF_FORM];
    status_out.bottom_of_form_line = status_q[SG_BOTTOM_OF_FORM];
    status_out.data_request_line = status_q[SG_DATA_REQUEST];
  end

  // Auxiliary controls straight from the latch flops
  always_comb begin
    aux_out.tape_upper_half_select = aux_q[AG_TAPE_UPPER];
    aux_out.tape_input_enable = aux_q[AG_TAPE_ENABLE];
    aux_out.format_high_select = aux_q[AG_FORMAT_HIGH];
    aux_out.panel_online_lamp = aux_q[AG_ONLINE_LAMP];
    aux_out.tape_motor_control = aux_q[AG_TAPE_MOTOR];
    aux_out.user_path_enable = aux_q[AG_USER_PATH];
    aux_out.band_id_bit_zero = aux_q[AG_BAND_ID_ZERO];
  end

  // Host pins cross in: three stages, a change counts when stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      host_sync1 <= 11'h000;
      host_sync2 <= 11'h000;
      host_sync3 <= 11'h000;
    end else begin
      host_sync1 <= {respond_latch_pulse_in, paper_instruction_bit_in, host_parity_bit_in,
                     host_data_in};
      host_sync2 <= host_sync1;
      host_sync3 <= host_sync2;
    end
  end

  // Strobe level seen once both late stages agree; filters a one-stage glitch
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      strobe_seen <= 1'b0;
    end else if (host_sync2[10] == host_sync3[10]) begin
      strobe_seen <= host_sync3[10];
    end
  end

  // Exclusive-OR stage inverts every bit when the low-true option is on
  always_comb begin
    next_user_byte = host_sync3[7:0] ^ {8{invert_input_option_in}};
  end

  // Capture on the rising edge of the respond latch pulse
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      user_byte <= 8'h00;
    end else if (host_sync2[10] && host_sync3[10] && !strobe_seen) begin
      user_byte <= next_user_byte;
    end
  end

  // Parity judged on the same edge as the capture; held until next byte
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      parity_fault_out <= 1'b0;
    end else if (host_sync2[10] && host_sync3[10] && !strobe_seen) begin
      parity_fault_out <= parity_option_in &&
        ((cover_parity(next_user_byte, parity_coverage_in, host_sync3[9]) ^
          host_sync3[8]) != odd_parity_select_in);
    end
  end

  // User byte onto the register bus only with read strobe and path enable
  assign processor_register_bus_oe_out =
    ~user_latch_read_strobe_n_in & aux_q[AG_USER_PATH];
  assign processor_register_bus_out = user_byte;

  // Source decoder: condition bit low with address bits 12 and 13 high enables it
  assign source_on = ~processor_condition_bit_n_in &
                     processor_address_bits_in[ADDR_SEL_HI] &
                     processor_address_bits_in[ADDR_LEVEL_BIT];
  assign src_sel = processor_address_bits_in[ADDR_SRC_HI:ADDR_SRC_LO];

  // One active-low enable per source; code seven selects nothing
  always_comb begin
    source_enable_n_out = 7'h7F;
    if (source_on && src_sel != 3'h7) begin
      source_enable_n_out[src_sel] = 1'b0;
    end
  end

  // Input bus multiplexer; unused code leaves the bus undriven
  always_comb begin
    processor_input_bus_oe_out = source_on && src_sel != 3'h7;
    case (src_sel)
      SRC_FORMS_LENGTH: processor_input_bus_out = sources_in.forms_length;
      SRC_USER_CONTROL: processor_input_bus_out = sources_in.user_control;
      SRC_SWITCH_GROUP2: processor_input_bus_out = sources_in.switch_group2;
      SRC_SWITCH_GROUP3: processor_input_bus_out = sources_in.switch_group3;
      SRC_SWITCH_GROUP4: processor_input_bus_out = sources_in.switch_group4;
      SRC_INTERLOCKS: processor_input_bus_out = sources_in.interlocks;
      SRC_PANEL: processor_input_bus_out = sources_in.panel;
      default: processor_input_bus_out = 8'h00;
    endcase
  end

  // Display load strobe from strobe group code 1101
  assign display_load = ~strobe_group_enable_n_in &&
    processor_address_bits_in[ADDR_STROBE_HI:ADDR_SEL_LO] == STROBE_DISPLAY_LOAD;
  assign display_load_strobe_n_out = ~display_load;

  // Status code latch; software writes the parity error code here after a bad byte
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      display_code <= DISPLAY_RESET;
    end else if (display_load) begin
      display_code <= processor_output_bus_in;
    end
  end

  // Two BCD digits, 00 to 99
  phic_seg_decoder u_tens (
    .digit_in(display_code[7:4]),
    .seg_out(seg_tens)
  );

  phic_seg_decoder u_units (
    .digit_in(display_code[3:0]),
    .seg_out(seg_units)
  );

  // Faults override the processor; clock fault first since the rest may be stale
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      display_tens_out <= SEG_BLANK;
      display_units_out <= SEG_BLANK;
    end else if (!clock_fault_n_in) begin
      display_tens_out <= SEG_BLANK;
      display_units_out <= SEG_LETTER_C;
    end else if (!supply_fault_n_in) begin
      display_tens_out <= SEG_BLANK;
      display_units_out <= SEG_LETTER_P;
    end else if (!overtemp_fault_n_in) begin
      display_tens_out <= SEG_BLANK;
      display_units_out <= SEG_LETTER_H;
    end else begin
      display_tens_out <= seg_tens;
      display_units_out <= seg_units;
    end
  end

endmodule : phic_host_iface

// ==== verification/phic_host_iface_assertions.sv ====
// Purpose: Port-level checks of the host interface control block
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only top-level ports; bound to every instance below
`timescale 1ns/1ns
module phic_host_iface_chk
  import phic_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [17:10] processor_address_bits_in,
  input wire logic status_group_enable_n_in,
  input wire logic aux_group_enable_n_in,
  input wire logic strobe_group_enable_n_in,
  input wire logic user_latch_read_strobe_n_in,
  input wire logic processor_register_bus_oe_out,
  input wire logic processor_input_bus_oe_out,
  input wire logic [6:0] source_enable_n_out,
  input wire phic_status_s status_out,
  input wire phic_aux_s aux_out,
  input wire logic parity_fault_out,
  input wire logic clock_fault_n_in,
  input wire logic display_load_strobe_n_out,
  input wire logic [6:0] display_tens_out,
  input wire logic [6:0] display_units_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  // A write changes only the selected output, one cycle after the enabled edge
  chk_status_write:
    assert property (!status_group_enable_n_in && processor_address_bits_in[12:10] == SG_READY
      |=> status_out.host_ready_line == $past(processor_address_bits_in[13])
      && {status_out[6:2], status_out[0]} == $past({status_out[6:2], status_out[0]}))
    else $error("status write wrong");
  chk_status_hold:
    assert property (status_group_enable_n_in |=> $stable(status_out))
    else $error("status changed while idle");
  chk_aux_write:
    assert property (!aux_group_enable_n_in && processor_address_bits_in[12:10] == AG_TAPE_MOTOR
      |=> aux_out.tape_motor_control == $past(processor_address_bits_in[13])
      && {aux_out[6:5], aux_out[3:0]} == $past({aux_out[6:5], aux_out[3:0]}))
    else $error("aux write wrong");
  chk_aux_hold:
    assert property (aux_group_enable_n_in |=> $stable(aux_out))
    else $error("aux changed while idle");
  // Reset check needs its own disable so that it runs during reset
  chk_reset_clear:
    assert property (disable iff (1'b0) !reset_n_in
      |=> status_out == '0 && aux_out == '0 && !parity_fault_out)
    else $error("reset did not clear");
  chk_read_gate:
    assert property (processor_register_bus_oe_out
      == (!user_latch_read_strobe_n_in && aux_out.user_path_enable))
    else $error("register bus gate wrong");
  chk_source_onehot:
    assert property (processor_input_bus_oe_out
      |-> source_enable_n_out == ~(7'h01 << processor_address_bits_in[17:15]))
    else $error("source enable wrong");
  chk_load_strobe:
    assert property (display_load_strobe_n_out
      == !(!strobe_group_enable_n_in && processor_address_bits_in[13:10] == 4'hD))
    else $error("load strobe wrong");
  chk_fault_letter:
    assert property (!clock_fault_n_in
      |=> display_units_out == SEG_LETTER_C && display_tens_out == SEG_BLANK)
    else $error("clock fault letter wrong");
endmodule : phic_host_iface_chk

bind phic_host_iface phic_host_iface_chk chk_u (.*);

// ==== verification/phic_host_model.sv ====
// Purpose: Behavioural host parallel controller on the user data pins
// Assumes: Called 1 ns after a rising edge of mclk_in
// Notes: Released lines show the inverse of the last value, never a stale copy
`timescale 1ns/1ns
module phic_host_model (
  input wire logic mclk_in,
  output logic [7:0] data_out,
  output logic parity_out,
  output logic pi_out,
  output logic pulse_out
);
  // Idle pins at time zero
  initial begin
    data_out = 8'h00;
    parity_out = 1'b0;
    pi_out = 1'b0;
    pulse_out = 1'b0;
  end

  // Data settles two cycles, pulse high three, held well past the capture
  task automatic send(input logic [7:0] d, input logic p, input logic i);
    data_out = d;
    parity_out = p;
    pi_out = i;
    repeat (2) @(posedge mclk_in);
    #1 pulse_out = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 pulse_out = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 data_out = ~d;
    parity_out = ~p;
    pi_out = ~i;
    repeat (3) @(posedge mclk_in);
    // Return off the edge so the caller's next change never lands on a sampling edge
    #1;
  endtask : send
endmodule : phic_host_model

// ==== verification/tb_phic_host_iface.sv ====
// Purpose: Self-checking bench for the host interface control block
// Assumes: 10 MHz clock, inputs change 1 ns after rising edges
// Notes: Random values from a fixed seed, with corner cases mixed in
`timescale 1ns/1ns
module tb_phic_host_iface
  import phic_pkg::*;
;
  logic mclk_in, reset_n_in, status_group_enable_n_in, aux_group_enable_n_in;
  logic strobe_group_enable_n_in, processor_condition_bit_n_in, user_latch_read_strobe_n_in;
  logic invert_input_option_in, parity_option_in, odd_parity_select_in;
  logic clock_fault_n_in, supply_fault_n_in, overtemp_fault_n_in;
  logic host_parity_bit_in, paper_instruction_bit_in, respond_latch_pulse_in;
  logic processor_register_bus_oe_out, processor_input_bus_oe_out, parity_fault_out;
  logic display_load_strobe_n_out, p, pib, inv, dec;
  logic [17:10] processor_address_bits_in;
  logic [7:0] processor_output_bus_in, processor_register_bus_out, processor_input_bus_out;
  logic [7:0] host_data_in, esg, eag, d;
  logic [6:0] source_enable_n_out, display_tens_out, display_units_out;
  logic [1:0] parity_coverage_in;
  phic_sources_s sources_in;
  phic_status_s status_out;
  phic_aux_s aux_out;
  int failures, num_checks, cyc;
  localparam logic [6:0] SEG_TAB [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  localparam logic [6:0] LETTERS [3] = '{SEG_LETTER_C, SEG_LETTER_P, SEG_LETTER_H};

  phic_host_iface dut_u (.*);
  phic_host_model host_u (.mclk_in(mclk_in), .data_out(host_data_in),
    .parity_out(host_parity_bit_in), .pi_out(paper_instruction_bit_in),
    .pulse_out(respond_latch_pulse_in));

  // Clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Latch write; the expectation only moves when the group is enabled
  task automatic wr(input logic grp, input logic [2:0] s, input logic lv, input logic en);
    processor_address_bits_in[13:10] = {lv, s};
    aux_group_enable_n_in = ~(en & grp);
    status_group_enable_n_in = ~(en & ~grp);
    tick(1);
    aux_group_enable_n_in = 1'b1;
    status_group_enable_n_in = 1'b1;
    if (en && grp) eag[s] = lv;
    if (en && !grp) esg[s] = lv;
  endtask : wr
  // Parity is taken on the byte as latched, after the optional inversion
  function automatic logic par_exp(logic [7:0] v, logic pb, logic pi, logic [1:0] c, logic o);
    logic s;
    s = (c == PAR_EIGHT) ? ^v : ((c == PAR_SEVEN_PI) ? ^{v[6:0], pi} : ^v[6:0]);
    return parity_option_in & ((s ^ pb) != o);
  endfunction : par_exp

  // Main sequence
  initial begin
    void'($urandom(32'h099E));
    {status_group_enable_n_in, aux_group_enable_n_in, strobe_group_enable_n_in} = 3'h7;
    {processor_condition_bit_n_in, user_latch_read_strobe_n_in} = 2'h3;
    {clock_fault_n_in, supply_fault_n_in, overtemp_fault_n_in} = 3'h7;
    {invert_input_option_in, parity_option_in, odd_parity_select_in} = 3'h0;
    parity_coverage_in = PAR_EIGHT;
    processor_address_bits_in = 8'h00;
    processor_output_bus_in = 8'h00;
    sources_in = '0;
    esg = 8'h00;
    eag = 8'h00;
    reset_n_in = 1'b0;
    tick(4);
    reset_n_in = 1'b1;
    check({status_out, aux_out, parity_fault_out}, 15'h0000);
    // Every code of both groups, the last pass with the enable withheld
    for (int k = 0; k < 64; k++) begin
      wr(k[0], k[3:1], 1'($urandom), k[5:4] != 2'h3);
      tick(1);
      check(status_out, {esg[7], esg[5:0]});
      check(aux_out, {eag[7:4], eag[2:0]});
    end
    wr(1'b1, AG_USER_PATH, 1'b1, 1'b1);
    // User bytes through every coverage choice; inversion only where parity is unaffected
    for (int k = 0; k < 24; k++) begin
      d = 8'($urandom);
      p = 1'($urandom);
      pib = 1'($urandom);
      parity_coverage_in = 2'(k % 3);
      inv = (k % 3 == 0) ? 1'($urandom) : 1'b0;
      invert_input_option_in = inv;
      odd_parity_select_in = 1'($urandom);
      parity_option_in = k < 20;
      tick(1);
      host_u.send(d, p, pib);
      user_latch_read_strobe_n_in = 1'b0;
      tick(1);
      check(processor_register_bus_oe_out, 1'b1);
      check(processor_register_bus_out, d ^ {8{inv}});
      check(parity_fault_out, par_exp(d ^ {8{inv}}, p, pib, parity_coverage_in,
        odd_parity_select_in));
      user_latch_read_strobe_n_in = 1'b1;
    end
    wr(1'b1, AG_USER_PATH, 1'b0, 1'b1);
    user_latch_read_strobe_n_in = 1'b0;
    tick(1);
    check(processor_register_bus_oe_out, 1'b0);
    user_latch_read_strobe_n_in = 1'b1;
    // Random decoder traffic; some passes force address bits 12 and 13 high so it enables
    for (int k = 0; k < 40; k++) begin
      processor_address_bits_in = 8'($urandom) | (k[1] ? 8'h0C : 8'h00);
      processor_condition_bit_n_in = k[0];
      sources_in = 56'({$urandom, $urandom});
      tick(1);
      dec = !k[0] && processor_address_bits_in[12] && processor_address_bits_in[13];
      check(source_enable_n_out, 7'(~(7'(dec) << processor_address_bits_in[17:15])));
      check(processor_input_bus_oe_out, dec && processor_address_bits_in[17:15] != 3'h7);
      if (dec && processor_address_bits_in[17:15] != 3'h7) check(processor_input_bus_out,
        sources_in[(6 - int'(processor_address_bits_in[17:15])) * 8 +: 8]);
    end
    processor_condition_bit_n_in = 1'b1;
    // Display loads, 00 and 99 first
    for (int k = 0; k < 12; k++) begin
      d = (k == 0) ? 8'h00 : ((k == 1) ? 8'h99 : {4'($urandom_range(9)), 4'($urandom_range(9))});
      processor_output_bus_in = d;
      processor_address_bits_in[13:10] = STROBE_DISPLAY_LOAD;
      strobe_group_enable_n_in = 1'b0;
      #1 check(display_load_strobe_n_out, 1'b0);
      tick(1);
      strobe_group_enable_n_in = 1'b1;
      tick(2);
      check({display_tens_out, display_units_out}, {SEG_TAB[d[7:4]], SEG_TAB[d[3:0]]});
    end
    // Each fault alone forces its letter
    for (int k = 0; k < 3; k++) begin
      {clock_fault_n_in, supply_fault_n_in, overtemp_fault_n_in} = ~(3'h4 >> k);
      tick(2);
      check({display_tens_out, display_units_out}, {SEG_BLANK, LETTERS[k]});
    end
    {clock_fault_n_in, supply_fault_n_in, overtemp_fault_n_in} = 3'h7;
    tick(2);
    // Reset in mid-run must clear what the writes and bytes left behind
    reset_n_in = 1'b0;
    tick(2);
    reset_n_in = 1'b1;
    check({status_out, aux_out, parity_fault_out}, 15'h0000);
    tick(2);
    results();
  end
endmodule : tb_phic_host_iface
